/* File: pcc_pkg.sv */
// Package: constants, types and register map of the capture/compare channel
package pcc_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned PCC_AW = 3;   // Register address width
  localparam int unsigned PCC_DW = 8;   // Register data width
  localparam int unsigned PCC_CW = 16;  // Counter and compare width

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [PCC_AW-1:0] PCC_OFS_MODE   = 3'h0;  // channel_mode_reg
  localparam logic [PCC_AW-1:0] PCC_OFS_CMP_LO = 3'h1;  // compare_low_byte
  localparam logic [PCC_AW-1:0] PCC_OFS_CMP_HI = 3'h2;  // compare_high_byte
  localparam logic [PCC_AW-1:0] PCC_OFS_PWMCTL = 3'h3;  // pwm_shared_ctrl
  localparam logic [PCC_AW-1:0] PCC_OFS_STATUS = 3'h4;  // Channel event flag
  localparam logic [PCC_AW-1:0] PCC_OFS_CNT_LO = 3'h5;  // counter_low_byte
  localparam logic [PCC_AW-1:0] PCC_OFS_CNT_HI = 3'h6;  // Counter high byte

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned PCC_WIDE_BIT  = 7;  // wide_pulse_select
  localparam int unsigned PCC_ECOM_BIT  = 6;  // comparator_enable
  localparam int unsigned PCC_CAPP_BIT  = 5;  // rising_capture_en
  localparam int unsigned PCC_CAPN_BIT  = 4;  // falling_capture_en
  localparam int unsigned PCC_MAT_BIT   = 3;  // match_enable
  localparam int unsigned PCC_TOG_BIT   = 2;  // toggle_enable
  localparam int unsigned PCC_PWM_BIT   = 1;  // pulse_mod_enable
  localparam int unsigned PCC_ECCF_BIT  = 0;  // channel_irq_enable
  localparam int unsigned PCC_RELOAD_REG_SELECT_BIT = 7;  // reload_reg_select
  localparam int unsigned PCC_PARTIAL_OVERFLOW_FLAG_BIT  = 6;  // partial_overflow_flag
  localparam int unsigned PCC_PARTIAL_OVERFLOW_IRQ_EN_BIT  = 5;  // partial_overflow_irq_en
  localparam int unsigned PCC_CYCLE_LENGTH_SEL_LSB = 0;  // cycle_length_sel, 2 bits
  localparam int unsigned PCC_CCF_BIT   = 0;  // channel_event_flag

  // ----------------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------------
  localparam logic [PCC_CW-1:0] PCC_CNT_MAX  = 16'hFFFF;
  localparam logic [PCC_CW-1:0] PCC_CNT_STEP = 16'h0001;
  localparam logic [1:0]        PCC_CYCLE_LENGTH_SEL_8  = 2'h0;
  // Counter bits that take part in an N-bit cycle, indexed by cycle length
  localparam logic [3:0][PCC_CW-1:0] PCC_LEN_MASK =
    {16'h07FF, 16'h03FF, 16'h01FF, 16'h00FF};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Register bus request
  typedef struct packed {
    logic [PCC_AW-1:0] addr;
    logic [PCC_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } pcc_bus_req_t;

  // Operating mode, one-hot
  typedef enum logic [6:0] {
    PCC_M_IDLE  = 7'h01,
    PCC_M_CAPT  = 7'h02,
    PCC_M_SWT   = 7'h04,
    PCC_M_HSO   = 7'h08,
    PCC_M_FREQ  = 7'h10,
    PCC_M_PULSE_MOD_ENABLE  = 7'h20,
    PCC_M_PWM16 = 7'h40
  } pcc_mode_t;

  // Whole state of the channel
  typedef struct packed {
    logic [PCC_DW-1:0] mode;   // channel_mode_reg
    logic [PCC_CW-1:0] cmp;    // Compare / capture register
    logic [PCC_CW-1:0] rld;    // Auto-reload register
    logic              reload_reg_select;  // reload_reg_select
    logic              partial_overflow_flag;   // partial_overflow_flag
    logic              partial_overflow_irq_en;   // partial_overflow_irq_en
    logic [1:0]        cycle_length_sel;  // cycle_length_sel
    logic              ccf;    // channel_event_flag
    logic [PCC_CW-1:0] cnt;    // Free-running counter
    logic              sync1;  // Pin synchroniser stage 1
    logic              sync2;  // Pin synchroniser stage 2
    logic              sync3;  // Previous synchronised level
    logic              pin;    // channel_pin output level
    logic              irq;    // Interrupt request
    logic [PCC_DW-1:0] rdata;  // Read data
  } pcc_state_t;

endpackage : pcc_pkg

/* File: pcc_channel.sv */
// Capture/compare channel with its counter, shared PWM control and register port
//
// Design decisions made here: the address-and-strobe port and the register addresses.
import pcc_pkg::*;

module pcc_channel (
  input  wire logic                  sys_clk_i,   // System clock, 250 MHz
  input  wire logic                  srst_i,      // Synchronous reset, high
  input  wire logic                  cnt_tick_i,  // Counter clock pulse
  input  wire logic                  channel_pin_i, // Pin level in
  input  wire pcc_pkg::pcc_bus_req_t bus_i,       // Register request
  output logic [pcc_pkg::PCC_DW-1:0] rdata_o,     // Read data
  output logic                       channel_pin_o, // Pin level out
  output logic                       irq_o        // Interrupt request
);
  import pcc_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  pcc_state_t        st_q;      // Registered state
  pcc_state_t        st_d;      // Next state
  pcc_mode_t         mode_s;    // Decoded operating mode
  logic [PCC_CW-1:0] cnt_nx;    // Counter after this tick
  logic [PCC_CW-1:0] len_mask;  // Active cycle bits for 8..11-bit PWM
  logic              ecom;      // Comparator enable
  logic              match16;   // Full 16-bit match on this tick
  logic              match_n;   // N-bit match on this tick
  logic              match_lo;  // Low-byte match on this tick
  logic              ovf_n;     // Overflow out of bit N on this tick
  logic              ovf_16;    // 16-bit overflow on this tick
  logic              edge_hit;  // Qualifying pin transition
  logic              set_ccf;   // Hardware sets channel event flag
  logic              clr_ccf;   // Software clears channel event flag
  logic              clr_partial_overflow_flag;  // Software clears overflow flag
  logic              wr_cmp_lo; // Write to compare low byte (not reload)
  logic              wr_cmp_hi; // Write to compare high byte (not reload)

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  // Capture bits take precedence; the comparator enable is left out here
  // so that clearing it gates the action without changing the mode.
  always_comb begin
    if (st_q.mode[PCC_CAPP_BIT] || st_q.mode[PCC_CAPN_BIT]) begin
      mode_s = PCC_M_CAPT;
    end else if (st_q.mode[PCC_PWM_BIT] && st_q.mode[PCC_WIDE_BIT]) begin
      mode_s = PCC_M_PWM16;
    end else if (st_q.mode[PCC_PWM_BIT] && st_q.mode[PCC_TOG_BIT]) begin
      mode_s = PCC_M_FREQ;
    end else if (st_q.mode[PCC_PWM_BIT]) begin
      mode_s = PCC_M_PULSE_MOD_ENABLE;
    end else if (st_q.mode[PCC_TOG_BIT] && st_q.mode[PCC_MAT_BIT]) begin
      mode_s = PCC_M_HSO;
    end else if (st_q.mode[PCC_MAT_BIT]) begin
      mode_s = PCC_M_SWT;
    end else begin
      mode_s = PCC_M_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // Counter events
  // ----------------------------------------------------------------------
  // All matches are taken against the value the counter moves to, so an
  // event lines up with the count that software programmed.
  always_comb begin
    cnt_nx   = st_q.cnt + PCC_CNT_STEP;
    len_mask = PCC_LEN_MASK[st_q.cycle_length_sel];
    ecom     = st_q.mode[PCC_ECOM_BIT];
    match16  = cnt_tick_i && (cnt_nx == st_q.cmp);
    match_n  = cnt_tick_i && ((cnt_nx & len_mask) == (st_q.cmp & len_mask));
    match_lo = cnt_tick_i && (cnt_nx[7:0] == st_q.cmp[7:0]);
    ovf_n    = cnt_tick_i && ((st_q.cnt & len_mask) == len_mask);
    ovf_16   = cnt_tick_i && (st_q.cnt == PCC_CNT_MAX);
    // Edge seen between the two synchronised samples, never stage 1
    edge_hit = (st_q.mode[PCC_CAPP_BIT] && st_q.sync2 && !st_q.sync3) ||
               (st_q.mode[PCC_CAPN_BIT] && !st_q.sync2 && st_q.sync3);
  end

  // ----------------------------------------------------------------------
  // Bus write decode
  // ----------------------------------------------------------------------
  always_comb begin
    wr_cmp_lo = bus_i.wr && (bus_i.addr == PCC_OFS_CMP_LO) && !st_q.reload_reg_select;
    wr_cmp_hi = bus_i.wr && (bus_i.addr == PCC_OFS_CMP_HI) && !st_q.reload_reg_select;
    clr_ccf   = bus_i.wr && (bus_i.addr == PCC_OFS_STATUS) &&
                !bus_i.wdata[PCC_CCF_BIT];
    clr_partial_overflow_flag  = bus_i.wr && (bus_i.addr == PCC_OFS_PWMCTL) &&
                !bus_i.wdata[PCC_PARTIAL_OVERFLOW_FLAG_BIT];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    set_ccf = 1'b0;

    // Pin synchroniser, then one more stage for edge detection
    st_d.sync1 = channel_pin_i;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;

    // Free-running counter advanced by the counter clock
    if (cnt_tick_i) begin
      st_d.cnt = cnt_nx;
    end

    // Software writes come first; hardware updates below override them
    if (bus_i.wr) begin
      case (bus_i.addr)
        PCC_OFS_MODE: begin
          st_d.mode = bus_i.wdata;
        end
        PCC_OFS_CMP_LO: begin
          if (st_q.reload_reg_select) begin
            st_d.rld[7:0] = bus_i.wdata;
          end else begin
            st_d.cmp[7:0]            = bus_i.wdata;
            st_d.mode[PCC_ECOM_BIT] = 1'b0;
          end
        end
        PCC_OFS_CMP_HI: begin
          if (st_q.reload_reg_select) begin
            st_d.rld[15:8] = bus_i.wdata;
          end else begin
            st_d.cmp[15:8]           = bus_i.wdata;
            st_d.mode[PCC_ECOM_BIT] = 1'b1;
          end
        end
        PCC_OFS_PWMCTL: begin
          st_d.reload_reg_select = bus_i.wdata[PCC_RELOAD_REG_SELECT_BIT];
          st_d.partial_overflow_irq_en  = bus_i.wdata[PCC_PARTIAL_OVERFLOW_IRQ_EN_BIT];
          st_d.cycle_length_sel = bus_i.wdata[PCC_CYCLE_LENGTH_SEL_LSB +: 2];
        end
        default: begin
          // Status and counter bytes hold no writable storage here
        end
      endcase
    end

    // Per-mode channel behaviour
    case (mode_s)
      PCC_M_CAPT: begin
        if (edge_hit) begin
          st_d.cmp = st_q.cnt;
          set_ccf  = 1'b1;
        end
      end
      PCC_M_SWT: begin
        if (ecom && match16) begin
          set_ccf = 1'b1;
        end
      end
      PCC_M_HSO: begin
        // With the comparator off the level is simply held
        if (ecom && match16) begin
          st_d.pin = !st_q.pin;
          set_ccf  = 1'b1;
        end
      end
      PCC_M_FREQ: begin
        // Adding a zero high byte leaves the low byte in place, so the
        // next match is a full 256 counts away
        if (ecom && match_lo) begin
          st_d.pin       = !st_q.pin;
          st_d.cmp[7:0]  = st_q.cmp[7:0] + st_q.cmp[15:8];
        end
        if (st_q.mode[PCC_MAT_BIT] && match16) begin
          set_ccf = 1'b1;
        end
      end
      PCC_M_PULSE_MOD_ENABLE: begin
        if (ovf_n) begin
          st_d.pin = 1'b0;
          if (st_q.cycle_length_sel == PCC_CYCLE_LENGTH_SEL_8) begin
            st_d.cmp[7:0] = st_q.cmp[15:8];
          end else begin
            st_d.cmp = st_q.rld;
          end
        end else if (match_n) begin
          st_d.pin = 1'b1;
          if (st_q.mode[PCC_MAT_BIT]) begin
            set_ccf = 1'b1;
          end
        end
        if (!ecom) begin
          st_d.pin = 1'b0;
        end
      end
      PCC_M_PWM16: begin
        if (ovf_16) begin
          st_d.pin = 1'b0;
        end else if (match16) begin
          st_d.pin = 1'b1;
          if (st_q.mode[PCC_MAT_BIT]) begin
            set_ccf = 1'b1;
          end
        end
        if (!ecom) begin
          st_d.pin = 1'b0;
        end
      end
      default: begin
        // Idle: pin holds its last level
      end
    endcase

    // Flags: hardware set wins over a software clear in the same cycle
    st_d.ccf  = set_ccf || (st_q.ccf && !clr_ccf);
    st_d.partial_overflow_flag = ovf_n || (st_q.partial_overflow_flag && !clr_partial_overflow_flag);

    // Interrupt request from enabled, set flags
    st_d.irq = (st_q.ccf && st_q.mode[PCC_ECCF_BIT]) ||
               (st_q.partial_overflow_flag && st_q.partial_overflow_irq_en);

    // Read data stands only in the cycle after the read strobe
    st_d.rdata = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        PCC_OFS_MODE:   st_d.rdata = st_q.mode;
        PCC_OFS_CMP_LO: st_d.rdata = st_q.reload_reg_select ? st_q.rld[7:0] : st_q.cmp[7:0];
        PCC_OFS_CMP_HI: st_d.rdata = st_q.reload_reg_select ? st_q.rld[15:8] : st_q.cmp[15:8];
        PCC_OFS_PWMCTL: begin
          st_d.rdata[PCC_RELOAD_REG_SELECT_BIT]        = st_q.reload_reg_select;
          st_d.rdata[PCC_PARTIAL_OVERFLOW_FLAG_BIT]         = st_q.partial_overflow_flag;
          st_d.rdata[PCC_PARTIAL_OVERFLOW_IRQ_EN_BIT]         = st_q.partial_overflow_irq_en;
          st_d.rdata[PCC_CYCLE_LENGTH_SEL_LSB +: 2]   = st_q.cycle_length_sel;
        end
        PCC_OFS_STATUS: st_d.rdata[PCC_CCF_BIT] = st_q.ccf;
        PCC_OFS_CNT_LO: st_d.rdata = st_q.cnt[7:0];
        PCC_OFS_CNT_HI: st_d.rdata = st_q.cnt[15:8];
        default:        st_d.rdata = '0;  // Unmapped reads as zero
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_o       = st_q.rdata;
  assign channel_pin_o = st_q.pin;
  assign irq_o         = st_q.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  property p_capture;
    (mode_s == PCC_M_CAPT) && edge_hit |=> st_q.ccf && (st_q.cmp == $past(st_q.cnt));
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");

  // A falling level on a rising-only channel must leave a clear flag clear
  property p_edge_sel;
    (mode_s == PCC_M_CAPT) && st_q.mode[PCC_CAPP_BIT] && !st_q.mode[PCC_CAPN_BIT] &&
      !st_q.sync2 && st_q.sync3 && !st_q.ccf |=> !st_q.ccf;
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("wrong edge used");

  property p_flag_sticky;
    st_q.ccf && !clr_ccf |=> st_q.ccf;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_irq;
    st_q.ccf && st_q.mode[PCC_ECCF_BIT] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");

  property p_swt;
    (mode_s == PCC_M_SWT) && ecom && match16 |=> st_q.ccf;
  endproperty
  a_swt: assert property (p_swt) else $error("timer match missed");

  property p_ecom_wr;
    wr_cmp_lo |=> !st_q.mode[PCC_ECOM_BIT];
  endproperty
  a_ecom_wr: assert property (p_ecom_wr) else $error("comparator enable");

  property p_ecom_set;
    wr_cmp_hi |=> st_q.mode[PCC_ECOM_BIT];
  endproperty
  a_ecom_set: assert property (p_ecom_set) else $error("comparator not set");

  property p_hso;
    (mode_s == PCC_M_HSO) && match16 |=> (channel_pin_o != $past(channel_pin_o)) == $past(ecom);
  endproperty
  a_hso: assert property (p_hso) else $error("toggle wrong");

  property p_pwm_off;
    ((mode_s == PCC_M_PULSE_MOD_ENABLE) || (mode_s == PCC_M_PWM16)) && !ecom && !bus_i.wr
      |=> ##1 !channel_pin_o;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm not low");

  property p_reload8;
    (mode_s == PCC_M_PULSE_MOD_ENABLE) && (st_q.cycle_length_sel == PCC_CYCLE_LENGTH_SEL_8) && ovf_n && !bus_i.wr
      |=> (st_q.cmp[7:0] == $past(st_q.cmp[15:8])) && !channel_pin_o;
  endproperty
  a_reload8: assert property (p_reload8) else $error("8-bit reload");

  property p_reloadn;
    (mode_s == PCC_M_PULSE_MOD_ENABLE) && (st_q.cycle_length_sel != PCC_CYCLE_LENGTH_SEL_8) && ovf_n && !bus_i.wr
      |=> (st_q.cmp == $past(st_q.rld)) && st_q.partial_overflow_flag;
  endproperty
  a_reloadn: assert property (p_reloadn) else $error("N-bit reload");

  c_capture: cover property ((mode_s == PCC_M_CAPT) && edge_hit);
  c_freq:    cover property ((mode_s == PCC_M_FREQ) && ecom && match_lo);
  c_pwm16:   cover property ((mode_s == PCC_M_PWM16) && ecom && match16);

endmodule : pcc_channel

/* File: pcc_pin_model.sv */
// Partner model: external source that drives the channel pin
module pcc_pin_model (
  input  wire logic sys_clk_i,     // System clock
  output logic      channel_pin_o  // Level driven onto the channel pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Pin driver
  // ----------------------------------------------------------------------
  // Pin idles low until the first transition is commanded
  initial channel_pin_o = 1'b0;

  // Change just after an edge, then hold; a shorter level could be missed
  task automatic drive(input logic lvl);
    @(posedge sys_clk_i) channel_pin_o <= lvl;
    repeat (4) @(posedge sys_clk_i);  // Level held past the two-cycle minimum
  endtask : drive
endmodule : pcc_pin_model

/* File: pcc_channel_tb_top.sv */
// Self-checking testbench of the capture/compare channel
module pcc_channel_tb_top import pcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic         sys_clk_i;   // 250 MHz clock
  logic         srst_i;      // Synchronous reset
  logic         cnt_tick_i;  // Counter advance
  logic         chan_pin;    // Pin level from the partner
  pcc_bus_req_t bus;         // Register request
  logic [7:0]   rdata;       // Read data
  logic         pin_out;     // Channel output level
  logic         irq;         // Interrupt request
  logic [15:0]  cnt_exp;     // Expected counter value
  logic [15:0]  v;           // Scratch compare value
  logic [7:0]   rv;          // Last read value
  logic         p0;          // Output level before a toggle
  int           bad_count;   // Mismatches
  int           n_checks;    // Comparisons

  pcc_pin_model i_pin (.sys_clk_i(sys_clk_i), .channel_pin_o(chan_pin));

  pcc_channel i_dut (
    .sys_clk_i    (sys_clk_i),
    .srst_i       (srst_i),
    .cnt_tick_i   (cnt_tick_i),
    .channel_pin_i(chan_pin),
    .bus_i        (bus),
    .rdata_o      (rdata),
    .channel_pin_o(pin_out),
    .irq_o        (irq)
  );

  // Free-running 4 ns clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i) begin
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
    end
    @(posedge sys_clk_i) bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe edge
  task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk_i) begin
      bus.addr <= a;
      bus.rd   <= 1'b1;
    end
    @(posedge sys_clk_i) bus.rd <= 1'b0;
    #1 rv = rdata;
    chk(rv & m, e);
  endtask : rchk

  task automatic pchk(input logic e);
    chk({7'h00, pin_out}, {7'h00, e});
  endtask : pchk

  // Low byte first so the comparator ends up enabled
  task automatic set_cmp(input logic [15:0] c);
    wr(PCC_OFS_CMP_LO, c[7:0]);
    wr(PCC_OFS_CMP_HI, c[15:8]);
  endtask : set_cmp

  // Advance the counter by n ticks; effects are settled on return
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i) cnt_tick_i <= 1'b1;
    @(posedge sys_clk_i) cnt_tick_i <= 1'b0;
    #1 cnt_exp = cnt_exp + 16'(n);
  endtask : tick

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rchk(PCC_OFS_MODE, 8'hFF, 8'h00);
    rchk(PCC_OFS_CNT_LO, 8'hFF, 8'h00);
    rchk(3'h7, 8'hFF, 8'h00);  // Unmapped place reads zero
    set_cmp(16'h1234);
    rchk(PCC_OFS_MODE, 8'h40, 8'h40);
    wr(PCC_OFS_CMP_LO, 8'h34);
    rchk(PCC_OFS_MODE, 8'h40, 8'h00);
  endtask : t_reset

  task automatic t_capture();
    logic [7:0] m;
    tick(int'(16'h0123));
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 8'h20 : (i == 1) ? 8'h10 : 8'h30;
      wr(PCC_OFS_MODE, m | 8'h01);
      wr(PCC_OFS_STATUS, 8'h00);
      i_pin.drive(1'b1);
      rchk(PCC_OFS_STATUS, 8'h01, {7'h00, m[5]});
      chk({7'h00, irq}, {7'h00, m[5]});
      wr(PCC_OFS_STATUS, 8'h00);
      i_pin.drive(1'b0);
      rchk(PCC_OFS_STATUS, 8'h01, {7'h00, m[4]});
    end
    rchk(PCC_OFS_CMP_LO, 8'hFF, cnt_exp[7:0]);
    rchk(PCC_OFS_CMP_HI, 8'hFF, cnt_exp[15:8]);
  endtask : t_capture

  task automatic t_swtimer();
    wr(PCC_OFS_MODE, 8'h09);
    set_cmp(cnt_exp + 16'h0005);
    wr(PCC_OFS_STATUS, 8'h00);  // Flag left set by the last capture
    tick(4);
    rchk(PCC_OFS_STATUS, 8'h01, 8'h00);
    tick(1);
    rchk(PCC_OFS_STATUS, 8'h01, 8'h01);
    rchk(PCC_OFS_STATUS, 8'h01, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(PCC_OFS_STATUS, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk({7'h00, irq}, 8'h00);
  endtask : t_swtimer

  task automatic t_hso();
    wr(PCC_OFS_MODE, 8'h0C);
    v = cnt_exp + 16'h0003;
    set_cmp(v);
    p0 = pin_out;
    tick(3);
    pchk(~p0);
    rchk(PCC_OFS_STATUS, 8'h01, 8'h01);
    v = cnt_exp + 16'h0003;
    wr(PCC_OFS_CMP_LO, v[7:0]);
    rchk(PCC_OFS_MODE, 8'h40, 8'h00);
    p0 = pin_out;
    tick(3);
    pchk(p0);
  endtask : t_hso

  task automatic t_freq();
    wr(PCC_OFS_MODE, 8'h06);
    v = {8'h03, cnt_exp[7:0] + 8'h02};
    set_cmp(v);
    p0 = pin_out;
    tick(2);
    pchk(~p0);
    rchk(PCC_OFS_CMP_LO, 8'hFF, v[7:0] + 8'h03);
    tick(2);
    pchk(~p0);
    tick(1);
    pchk(p0);
    wr(PCC_OFS_CMP_HI, 8'h00);  // Zero high byte: 256-count half period
    tick(3);
    pchk(~p0);
    tick(255);
    pchk(~p0);
    tick(1);
    pchk(p0);
  endtask : t_freq

  task automatic t_pwm8();
    wr(PCC_OFS_PWMCTL, 8'h20);  // Clears stale overflow flag, enables its request
    wr(PCC_OFS_STATUS, 8'h00);
    wr(PCC_OFS_MODE, 8'h0A);
    set_cmp(16'hC080);  // Low byte differs so the reload shows
    tick(256 - int'(cnt_exp[7:0]));
    pchk(1'b0);
    rchk(PCC_OFS_CMP_LO, 8'hFF, 8'hC0);
    rchk(PCC_OFS_PWMCTL, 8'h40, 8'h40);
    chk({7'h00, irq}, 8'h01);
    wr(PCC_OFS_PWMCTL, 8'h00);
    wr(PCC_OFS_STATUS, 8'h00);
    tick(192);
    pchk(1'b1);
    rchk(PCC_OFS_STATUS, 8'h01, 8'h01);
    tick(64);
    pchk(1'b0);
    wr(PCC_OFS_CMP_LO, 8'hC0);
    tick(192);
    pchk(1'b0);
  endtask : t_pwm8

  task automatic t_pwm9();
    wr(PCC_OFS_PWMCTL, 8'h81);
    wr(PCC_OFS_CMP_LO, 8'h80);
    wr(PCC_OFS_CMP_HI, 8'h01);
    rchk(PCC_OFS_CMP_LO, 8'hFF, 8'h80);
    wr(PCC_OFS_PWMCTL, 8'h01);
    rchk(PCC_OFS_CMP_LO, 8'hFF, 8'hC0);
    wr(PCC_OFS_MODE, 8'h4A);
    tick(512 - int'(cnt_exp[8:0]));
    rchk(PCC_OFS_CMP_HI, 8'hFF, 8'h01);
    rchk(PCC_OFS_CMP_LO, 8'hFF, 8'h80);
    rchk(PCC_OFS_PWMCTL, 8'h40, 8'h40);
    pchk(1'b0);
    tick(384);
    pchk(1'b1);
  endtask : t_pwm9

  // Cycle-length field stays at 9 bits to show it has no say here
  task automatic t_pwm16();
    wr(PCC_OFS_MODE, 8'h82);
    set_cmp(cnt_exp + 16'h0004);
    tick(4);
    pchk(1'b1);
    tick(65536 - int'(cnt_exp));
    pchk(1'b0);
  endtask : t_pwm16

  // ----------------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------------
  initial begin
    srst_i     = 1'b1;
    cnt_tick_i = 1'b0;
    bus        = '0;
    cnt_exp    = 16'h0000;
    bad_count  = 0;
    n_checks   = 0;
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    t_reset();
    t_capture();
    t_swtimer();
    t_hso();
    t_freq();
    t_pwm8();
    t_pwm9();
    t_pwm16();
    print_verdict();
  end

  // Whole run fits well inside this bound; running out counts as a mismatch
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    bad_count++;
    print_verdict();
  end
endmodule : pcc_channel_tb_top
